// ---- core/nsfc_defs.vh ----
/*
 Constants of the NAND status and feature controller.
 Assumes inclusion by bare name from files under core/.
*/
`ifndef NSFC_DEFS_VH
`define NSFC_DEFS_VH
// Wishbone register offsets (byte addresses)
`define NSFC_REG_CTRL 8'h00
`define NSFC_REG_ROW 8'h04
`define NSFC_REG_FEAT 8'h08
`define NSFC_REG_PARAM 8'h0c
`define NSFC_REG_STAT 8'h10
`define NSFC_REG_RESULT 8'h14
`define NSFC_REG_DRIVE 8'h18
`define NSFC_REG_ARRAY 8'h1c
// Control operation codes
`define NSFC_OP_STATUS 2'h0
`define NSFC_OP_STATUS_ADDR 2'h1
`define NSFC_OP_SET_FEAT 2'h2
`define NSFC_OP_RESET 2'h3
// Device command codes
`define NSFC_CMD_STATUS 8'h70
`define NSFC_CMD_STATUS_ADDR 8'h78
`define NSFC_CMD_SET_FEAT 8'hef
`define NSFC_CMD_RESET 8'hff
`define NSFC_CMD_READ 8'h00
// Feature addresses and values
`define NSFC_FA_DRIVE 8'h10
`define NSFC_FA_ARRAY 8'h90
`define NSFC_DRIVE_DEFAULT 8'h00
`define NSFC_DRIVE_MAX 8'h03
`define NSFC_ECC_ON 8'h08
`define NSFC_ECC_OFF 8'h00
// Status bit positions
`define NSFC_SB_FAIL 0
`define NSFC_SB_PREV_FAIL 1
`define NSFC_SB_ECC_LO 3
`define NSFC_SB_ECC_HI 4
`define NSFC_SB_ARRAY_IDLE 5
`define NSFC_SB_READY 6
`define NSFC_SB_UNPROT 7
// Strobe timing: each phase in ns and in 25 ns cycles
`define NSFC_T_PHASE_NS 50
`define NSFC_CLK_NS 25
`define NSFC_T_PHASE_CYC ((`NSFC_T_PHASE_NS + `NSFC_CLK_NS - 1) / `NSFC_CLK_NS)
`endif

// ---- core/nsfc_param_mem.v ----
/*
 Small register-output memory holding the four feature parameter bytes.
 Assumes one write or one read per clock, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module nsfc_param_mem #(
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Write port
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [7:0] wdata,
    // Read port
    input wire [AW-1:0] raddr,
    output reg [7:0] rdata_q
);
reg [7:0] mem [0:DEPTH-1];
always @(posedge clk)
begin
    if (we)
    begin
        mem[waddr] <= wdata;
    end
end
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        rdata_q <= 8'h00;
    end
    else
    begin
        rdata_q <= mem[raddr];
    end
end
endmodule // nsfc_param_mem
`default_nettype wire

// ---- core/nsfc_ctrl.v ----
/*
 Host-side controller issuing status reads and set-feature sequences to a
 NAND device over its asynchronous pins, ordered over classic Wishbone.
 Assumes pins synchronous to clk and a single device on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nsfc_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Status command 70h, then every read cycle returns status byte.
// - After status during random read, send 00h before reading data; the controller has no op that sends 00h.
// - Addressed status: 78h then three row address cycles.
// - No addressed status during reset or one-time-programmable mode.
// - No reset command inside a set-feature sequence.
module nsfc_ctrl #(
    parameter ROWS = 3,
    parameter NPARAM = 4
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // NAND pins
    output reg chip_select_n,
    output reg cmd_latch,
    output reg addr_latch,
    output reg write_strobe_n,
    output reg read_strobe_n,
    output reg [7:0] io_out,
    output reg io_oe,
    input wire [7:0] io_in,
    input wire ready_busy_n
);
localparam S_IDLE = 3'h0;
localparam S_CMD = 3'h1;
localparam S_ADDR = 3'h2;
localparam S_DATA = 3'h3;
localparam S_READ = 3'h4;
localparam S_WAIT = 3'h5;
localparam S_DONE = 3'h6;
localparam [31:0] PHASE_W = `NSFC_T_PHASE_CYC;
localparam [7:0] PHASE = PHASE_W[7:0];
reg [2:0] state_q;
reg [7:0] tmr_q;
reg [1:0] op_q;
reg [2:0] idx_q;
reg low_q;
reg busy_q;
reg start_q;
reg [1:0] start_op_q;
reg [23:0] row_q;
reg [7:0] fa_q;
reg [7:0] status_value_q;
reg [7:0] drive_q;
reg [7:0] array_q;
reg [2:0] result_q;
reg poll_q;
wire [7:0] pm_rdata;
wire pm_we;
wire req;
wire [7:0] cmd_code;
assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign pm_we = req && wb_we_i && wb_adr_i == `NSFC_REG_PARAM && wb_sel_i[0];
////////////////////////////////////////////////////////////////////////////////
// Helpers
function [7:0] op_cmd;
    input [1:0] op;
    begin
        if (op == `NSFC_OP_STATUS)
            op_cmd = `NSFC_CMD_STATUS;
        else if (op == `NSFC_OP_STATUS_ADDR)
            op_cmd = `NSFC_CMD_STATUS_ADDR;
        else if (op == `NSFC_OP_SET_FEAT)
            op_cmd = `NSFC_CMD_SET_FEAT;
        else
            op_cmd = `NSFC_CMD_RESET;
    end
endfunction
// Decode ECC class from bits 4,3,0
function [2:0] ecc_class;
    input [7:0] s;
    begin
        case ({s[`NSFC_SB_ECC_HI], s[`NSFC_SB_ECC_LO], s[`NSFC_SB_FAIL]})
            3'b001: ecc_class = 3'h4;
            3'b000: ecc_class = 3'h0;
            3'b010: ecc_class = 3'h1;
            3'b100: ecc_class = 3'h2;
            3'b110: ecc_class = 3'h3;
            default: ecc_class = 3'h7;
        endcase
    end
endfunction
// Feature write accepted only for known address and legal bytes
function feat_ok;
    input [7:0] fa;
    input [7:0] p1;
    begin
        if (fa == `NSFC_FA_DRIVE)
            feat_ok = p1 <= `NSFC_DRIVE_MAX;
        else if (fa == `NSFC_FA_ARRAY)
            feat_ok = p1 == `NSFC_ECC_ON || p1 == `NSFC_ECC_OFF;
        else
            feat_ok = 1'b0;
    end
endfunction
assign cmd_code = op_cmd(op_q);
nsfc_param_mem #(
    .DEPTH(NPARAM),
    .AW(2)
) u_param (
    .clk(clk),
    .arst_n(arst_n),
    .we(pm_we),
    .waddr(wb_dat_i[9:8]),
    .wdata(wb_dat_i[7:0]),
    .raddr(idx_q[1:0]),
    .rdata_q(pm_rdata)
);
reg [7:0] res_nz_q;
reg [7:0] p1_q;
////////////////////////////////////////////////////////////////////////////////
// Wishbone slave, one wait state
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
        start_q <= 1'b0;
        start_op_q <= 2'h0;
        row_q <= 24'h0;
        fa_q <= 8'h0;
        poll_q <= 1'b0;
    end
    else
    begin
        wb_ack_o <= req;
        start_q <= 1'b0;
        wb_dat_o <= 32'h0;
        if (req && wb_we_i)
        begin
            if (wb_adr_i == `NSFC_REG_CTRL)
            begin
                // start ignored while a sequence runs
                if (wb_sel_i[0] && !busy_q)
                begin
                    start_q <= 1'b1;
                    start_op_q <= wb_dat_i[1:0];
                    poll_q <= wb_dat_i[2];
                end
            end
            else if (wb_adr_i == `NSFC_REG_ROW)
            begin
                if (wb_sel_i[0]) row_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) row_q[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) row_q[23:16] <= wb_dat_i[23:16];
            end
            else if (wb_adr_i == `NSFC_REG_FEAT)
            begin
                if (wb_sel_i[0]) fa_q <= wb_dat_i[7:0];
            end
        end
        else if (req)
        begin
            if (wb_adr_i == `NSFC_REG_CTRL)
                wb_dat_o <= {29'h0, poll_q, op_q};
            else if (wb_adr_i == `NSFC_REG_ROW)
                wb_dat_o <= {8'h0, row_q};
            else if (wb_adr_i == `NSFC_REG_FEAT)
                wb_dat_o <= {24'h0, fa_q};
            else if (wb_adr_i == `NSFC_REG_STAT)
                wb_dat_o <= {23'h0, ready_busy_n, busy_q, 7'h0};
            else if (wb_adr_i == `NSFC_REG_RESULT)
                wb_dat_o <= {21'h0, result_q, status_value_q};
            else if (wb_adr_i == `NSFC_REG_DRIVE)
                wb_dat_o <= {24'h0, drive_q};
            else if (wb_adr_i == `NSFC_REG_ARRAY)
                wb_dat_o <= {24'h0, array_q};
            else
                wb_dat_o <= 32'h0;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// NAND sequencer
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state_q <= S_IDLE;
        tmr_q <= 8'h0;
        op_q <= 2'h0;
        idx_q <= 3'h0;
        low_q <= 1'b0;
        busy_q <= 1'b0;
        chip_select_n <= 1'b1;
        cmd_latch <= 1'b0;
        addr_latch <= 1'b0;
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        io_out <= 8'h0;
        io_oe <= 1'b0;
        status_value_q <= 8'h0;
        result_q <= 3'h0;
        drive_q <= `NSFC_DRIVE_DEFAULT;
        array_q <= `NSFC_ECC_ON;
        res_nz_q <= 8'h0;
        p1_q <= 8'h0;
    end
    else
    begin
        if (tmr_q != 8'h0)
            tmr_q <= tmr_q - 8'h01;
        case (state_q)
            S_IDLE:
            begin
                chip_select_n <= 1'b1;
                io_oe <= 1'b0;
                if (start_q)
                begin
                    op_q <= start_op_q;
                    busy_q <= 1'b1;
                    idx_q <= 3'h0;
                    low_q <= 1'b0;
                    res_nz_q <= 8'h0;
                    chip_select_n <= 1'b0;
                    tmr_q <= PHASE;
                    state_q <= S_CMD;
                end
            end
            S_CMD:
            begin
                if (tmr_q == 8'h0)
                begin
                    if (!low_q)
                    begin
                        cmd_latch <= 1'b1;
                        io_out <= cmd_code;
                        io_oe <= 1'b1;
                        write_strobe_n <= 1'b0;
                        low_q <= 1'b1;
                    end
                    else
                    begin
                        // Latch held past the rising strobe
                        write_strobe_n <= 1'b1;
                        low_q <= 1'b0;
                        if (op_q == `NSFC_OP_STATUS_ADDR ||
                            op_q == `NSFC_OP_SET_FEAT)
                            state_q <= S_ADDR;
                        else if (op_q == `NSFC_OP_STATUS)
                            state_q <= S_READ;
                        else
                            state_q <= S_WAIT;
                    end
                    tmr_q <= PHASE;
                end
            end
            S_ADDR:
            begin
                if (tmr_q == 8'h0)
                begin
                    if (!low_q)
                    begin
                        addr_latch <= 1'b1;
                        cmd_latch <= 1'b0;
                        write_strobe_n <= 1'b0;
                        low_q <= 1'b1;
                        if (op_q == `NSFC_OP_SET_FEAT)
                            io_out <= fa_q;
                        else if (idx_q == 3'h0)
                            io_out <= row_q[7:0];
                        else if (idx_q == 3'h1)
                            io_out <= row_q[15:8];
                        else
                            io_out <= row_q[23:16];
                    end
                    else
                    begin
                        write_strobe_n <= 1'b1;
                        low_q <= 1'b0;
                        idx_q <= idx_q + 3'h1;
                        if (op_q == `NSFC_OP_SET_FEAT)
                        begin
                            idx_q <= 3'h0;
                            state_q <= S_DATA;
                        end
                        else if (idx_q == ROWS - 1)
                            state_q <= S_READ;
                    end
                    tmr_q <= PHASE;
                end
            end
            S_DATA:
            begin
                // Parameter byte read from memory one phase ahead
                if (tmr_q == 8'h0)
                begin
                    if (!low_q)
                    begin
                        io_out <= pm_rdata;
                        addr_latch <= 1'b0;
                        if (idx_q == 3'h0)
                            p1_q <= pm_rdata;
                        else
                            res_nz_q <= res_nz_q | pm_rdata;
                        write_strobe_n <= 1'b0;
                        low_q <= 1'b1;
                    end
                    else
                    begin
                        write_strobe_n <= 1'b1;
                        low_q <= 1'b0;
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == NPARAM - 1)
                            state_q <= S_WAIT;
                    end
                    tmr_q <= PHASE;
                end
            end
            S_READ:
            begin
                io_oe <= 1'b0;
                cmd_latch <= 1'b0;
                addr_latch <= 1'b0;
                if (tmr_q == 8'h0)
                begin
                    if (!low_q)
                    begin
                        read_strobe_n <= 1'b0;
                        low_q <= 1'b1;
                        tmr_q <= PHASE;
                    end
                    else
                    begin
                        // level sampled again while strobe stays low
                        status_value_q <= io_in;
                        result_q <= ecc_class(io_in);
                        if (!poll_q || io_in[`NSFC_SB_READY])
                        begin
                            read_strobe_n <= 1'b1;
                            low_q <= 1'b0;
                            state_q <= S_DONE;
                        end
                    end
                end
            end
            S_WAIT:
            begin
                io_oe <= 1'b0;
                cmd_latch <= 1'b0;
                if (tmr_q == 8'h0 && ready_busy_n)
                begin
                    if (op_q == `NSFC_OP_SET_FEAT && res_nz_q == 8'h0 &&
                        feat_ok(fa_q, p1_q))
                    begin
                        if (fa_q == `NSFC_FA_DRIVE)
                            drive_q <= p1_q;
                        else
                            array_q <= p1_q;
                    end
                    state_q <= S_DONE;
                end
            end
            S_DONE:
            begin
                // no read command (00h) is issued; chip select released, busy cleared
                chip_select_n <= 1'b1;
                busy_q <= 1'b0;
                state_q <= S_IDLE;
            end
            default:
            begin
                state_q <= S_IDLE;
            end
        endcase
    end
end
endmodule // nsfc_ctrl
`default_nettype wire

// ---- testbench/nsfc_ctrl_asserts.sv ----
/* Port checks of the NAND status and feature controller.
   Assumes binding onto nsfc_ctrl with one clock. */
`timescale 1ns/1ps
`default_nettype none
module nsfc_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // NAND pins
    input wire logic chip_select_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_taken: assert property
        ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_unmapped_zero: assert property
        ((wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_strobe_select: assert property (
        (!write_strobe_n || !read_strobe_n) |-> !chip_select_n)
        else $error("strobe without chip select");
    a_we_width: assert property (
        $fell(write_strobe_n) |=> !write_strobe_n [*2] ##1 write_strobe_n)
        else $error("write strobe width wrong");
    a_latch_hold: assert property (
        $rose(write_strobe_n) |-> $stable(cmd_latch) && $stable(addr_latch))
        else $error("latch dropped with write strobe");
    a_io_hold: assert property (
        (!write_strobe_n && !$past(write_strobe_n)) |-> io_oe && $stable(io_out))
        else $error("bus changed in write strobe");
    a_cmd_code: assert property (
        (cmd_latch && !write_strobe_n)
        |-> io_out inside {8'h70, 8'h78, 8'hef, 8'hff})
        else $error("unknown command code");
    a_read_free: assert property (
        !read_strobe_n |-> !io_oe && !cmd_latch && !addr_latch)
        else $error("bus driven during read");
    a_re_width: assert property (
        $fell(read_strobe_n) |=> !read_strobe_n)
        else $error("read strobe too short");
    a_cs_idle: assert property ($rose(chip_select_n)
        |-> write_strobe_n && read_strobe_n && !io_oe)
        else $error("deselect while active");
endmodule // nsfc_ctrl_chk
bind nsfc_ctrl nsfc_ctrl_chk u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .chip_select_n, .cmd_latch,
    .addr_latch, .write_strobe_n, .read_strobe_n, .io_out, .io_oe);
`default_nettype wire

// ---- testbench/nsfc_dev_model.sv ----
/* Behavioural NAND device: status output and two volatile features.
   Assumes the controller pins; after 78h bit 2 of status echoes the LUN bit. */
`timescale 1ns/1ps
`default_nettype none
module nsfc_dev_model (
    // Controller pins
    input wire logic chip_select_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    // Status source
    input wire logic [7:0] stat_i,
    // Device side
    output logic [7:0] io_in,
    output logic ready_busy_n,
    output logic [7:0] drive_o,
    output logic [7:0] array_o
);
    logic [7:0] cmd_q = 8'h00;
    logic [7:0] fa_q = 8'h00;
    logic [7:0] p_q [0:3];
    logic [7:0] rsv;
    logic [7:0] stv;
    logic drv;
    int n_q = 0;
    event go_busy;
    ////////////////////////////////////////////////////////////
    initial
    begin
        ready_busy_n = 1'b1;
        drive_o = 8'h00;
        array_o = 8'h08;
    end
    always @(go_busy)
    begin
        ready_busy_n = 1'b0;
        #250 ready_busy_n = 1'b1;
    end
    always @(posedge write_strobe_n)
        if (!chip_select_n)
        begin
            if (cmd_latch)
            begin
                cmd_q = io_out;
                n_q = 0;
                if (io_out == 8'hff)
                    -> go_busy;
            end
            else if (addr_latch)
                fa_q = io_out;
            else if (cmd_q == 8'hef && n_q < 4)
            begin
                p_q[n_q] = io_out;
                n_q = n_q + 1;
                if (n_q == 4)
                begin
                    rsv = p_q[1] | p_q[2] | p_q[3];
                    if (rsv == 8'h00 && fa_q == 8'h10 && p_q[0] <= 8'h03)
                        drive_o = p_q[0];
                    if (rsv == 8'h00 && fa_q == 8'h90 &&
                        (p_q[0] == 8'h08 || p_q[0] == 8'h00))
                        array_o = p_q[0];
                    -> go_busy;
                end
            end
        end
    assign stv = {stat_i[7], stat_i[6] & ready_busy_n,
        stat_i[5] & ready_busy_n, stat_i[4:3],
        cmd_q == 8'h78 ? fa_q[0] : stat_i[2], stat_i[1:0]};
    assign drv = !chip_select_n && !read_strobe_n &&
        (cmd_q == 8'h70 || cmd_q == 8'h78);
    assign io_in = io_oe ? io_out : drv ? stv : ~io_out;
endmodule // nsfc_dev_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Bench of the controller with the device model on its pins.
   Assumes core/ on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "nsfc_defs.vh"
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [7:0] stat = 8'he0;
    logic [31:0] rd;
    wire [31:0] wb_dat_o;
    wire [7:0] io_out, io_in, drive_o, array_o;
    wire wb_ack_o, chip_select_n, cmd_latch, addr_latch, io_oe;
    wire write_strobe_n, read_strobe_n, ready_busy_n;
    int err_total = 0;
    int checked = 0;
    int i;
    logic [7:0] e_st [0:5] = '{8'he1, 8'hc2, 8'he8, 8'hf0, 8'hf8, 8'h69};
    logic [2:0] e_cl [0:5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [7:0] f_fa [0:5] = '{8'h10, 8'h90, 8'h20, 8'h10, 8'h10, 8'h90};
    logic [31:0] f_p [0:5] = '{32'h3, 32'h0, 32'h1, 32'h4, 32'h01000001,
        32'h8};
    logic [7:0] f_dr [0:5] = '{8'h3, 8'h3, 8'h3, 8'h3, 8'h3, 8'h3};
    logic [7:0] f_ar [0:5] = '{8'h8, 8'h0, 8'h0, 8'h0, 8'h0, 8'h8};
    ////////////////////////////////////////////////////////////
    nsfc_ctrl u_dut (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n,
        .read_strobe_n, .io_out, .io_oe, .io_in, .ready_busy_n);
    nsfc_dev_model u_dev (.chip_select_n, .cmd_latch, .addr_latch,
        .write_strobe_n, .read_strobe_n, .io_out, .io_oe, .stat_i(stat),
        .io_in, .ready_busy_n, .drive_o, .array_o);
    initial
        forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n = n + 1;
        end
        rd = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic op(input logic [2:0] c);
        int n;
        n = 0;
        wb(1'b1, `NSFC_REG_CTRL, {29'h0, c});
        rd = 32'h80;
        while (rd[7] !== 1'b0 && n < 200)
        begin
            wb(1'b0, `NSFC_REG_STAT, 32'h0);
            n = n + 1;
        end
        chk(rd & 32'h80, 32'h0);
    endtask
    task automatic setf(input logic [7:0] fa, input logic [31:0] p);
        int k;
        wb(1'b1, `NSFC_REG_FEAT, {24'h0, fa});
        for (k = 0; k < 4; k++)
            wb(1'b1, `NSFC_REG_PARAM, {22'h0, k[1:0], p[8*k +: 8]});
        op(3'h2);
    endtask
    task automatic feats(input logic [7:0] dr, input logic [7:0] ar);
        wb(1'b0, `NSFC_REG_DRIVE, 32'h0);
        chk(rd, {24'h0, dr});
        wb(1'b0, `NSFC_REG_ARRAY, 32'h0);
        chk(rd, {24'h0, ar});
        chk({drive_o, array_o}, {16'h0, dr, ar});
    endtask
    task automatic close_out;
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        #500000;
        err_total = err_total + 1;
        close_out;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        feats(8'h00, 8'h08);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 6; i++)
        begin
            stat <= e_st[i];
            op(3'h0);
            wb(1'b0, `NSFC_REG_RESULT, 32'h0);
            chk(rd, {21'h0, e_cl[i], e_st[i]});
        end
        stat <= 8'he0;
        wb(1'b1, `NSFC_REG_ROW, 32'h01abcd);
        op(3'h1);
        wb(1'b0, `NSFC_REG_RESULT, 32'h0);
        chk(rd, 32'he4);
        for (i = 0; i < 6; i++)
        begin
            setf(f_fa[i], f_p[i]);
            feats(f_dr[i], f_ar[i]);
        end
        op(3'h3);
        feats(8'h03, 8'h08);
        stat <= 8'ha0;
        wb(1'b1, `NSFC_REG_CTRL, 32'h4);
        repeat (30) @(posedge clk);
        wb(1'b0, `NSFC_REG_STAT, 32'h0);
        chk(rd & 32'h80, 32'h80);
        wb(1'b1, `NSFC_REG_CTRL, 32'h0);
        wb(1'b0, `NSFC_REG_CTRL, 32'h0);
        chk(rd, 32'h4);
        stat <= 8'he0;
        op(3'h0);
        wb(1'b0, `NSFC_REG_RESULT, 32'h0);
        chk(rd, 32'he0);
        close_out;
    end
endmodule // tb_top
`default_nettype wire
